// file: design/rtc_time_counters.sv
// Time and date counter registers with integrity flag and access freeze
//
// Functional notes
// - Integrity flag lives in seconds bit 7, 1 means suspect, reads 1 at reset.
// - Seconds kept in BCD, tens in bits 6..4 (0-5), units 3..0.
// - Supply below low-voltage threshold sets the integrity flag.
// - Integrity flag stays set until the host writes it clear.
// - Oscillator stop also sets the integrity flag.
// - Minutes kept in BCD, tens bits 6..4, units 3..0, bit 7 zero.
// - Hours kept in BCD, tens bits 5..4 (0-2), bits 7..6 zero.
// - Day of month in BCD, tens bits 5..4 (0-3), bits 7..6 zero.
// - February gets day 29 when the year is divisible by four.
// - Weekday is three bits, counts 0 to 6, host may write 7, upper bits read zero.
// - Weekday default coding Sunday 0 through Saturday 6.
// - Month bit 7 is century flag, toggled on year 99 to 00.
// - Month in BCD 1-12, tens bit 4, bits 6..5 zero.
// - Year register at 08h holds two BCD digits 00 to 99.
// - Host access freezes counting; one tick is kept and applied afterwards.
`include "rtc_time_map.svh"

module rtc_time_counters (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Time base and monitors
  input  wire logic       tick_1hz,
  input  wire logic       supply_low,
  input  wire logic       osc_stopped,
  // Register port from the serial target
  input  wire logic       access_active,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Status
  output logic            clock_integrity_lost
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  rtc_time_pkg::hold_state_t state_q;
  rtc_time_pkg::hold_state_t state_d;
  logic                      step;
  logic                      flag_q;
  logic                      flag_d;
  logic [7:0]                sec_q;
  logic [7:0]                sec_d;
  logic [7:0]                min_q;
  logic [7:0]                min_d;
  logic [7:0]                hour_q;
  logic [7:0]                hour_d;
  logic [7:0]                day_q;
  logic [7:0]                day_d;
  logic [2:0]                wday_q;
  logic [2:0]                wday_d;
  logic [7:0]                month_q;
  logic [7:0]                month_d;
  logic [7:0]                year_q;
  logic [7:0]                year_d;
  logic                      cent_q;
  logic                      cent_d;
  logic [7:0]                rdata_d;
  logic [7:0]                sec_n;
  logic [7:0]                min_n;
  logic [7:0]                hour_n;
  logic [7:0]                day_n;
  logic [2:0]                wday_n;
  logic [7:0]                month_n;
  logic [7:0]                year_n;
  logic                      cent_n;

  // --------------------------------------------------------------------
  // Next time value
  // --------------------------------------------------------------------
  calendar_step u_step (
    .sec     (sec_q),
    .min     (min_q),
    .hour    (hour_q),
    .day     (day_q),
    .wday    (wday_q),
    .month   (month_q),
    .year    (year_q),
    .cent    (cent_q),
    .sec_n   (sec_n),
    .min_n   (min_n),
    .hour_n  (hour_n),
    .day_n   (day_n),
    .wday_n  (wday_n),
    .month_n (month_n),
    .year_n  (year_n),
    .cent_n  (cent_n)
  );

  // --------------------------------------------------------------------
  // Access freeze
  // --------------------------------------------------------------------
  // Only one tick is remembered; accesses over a second lose time
  always_comb begin
    state_d = state_q;
    step    = 1'b0;
    case (state_q)
      rtc_time_pkg::ST_RUN: begin
        if (access_active)
          state_d = tick_1hz ? rtc_time_pkg::ST_PEND
                             : rtc_time_pkg::ST_HOLD;
        else
          step = tick_1hz;
      end
      rtc_time_pkg::ST_HOLD: begin
        if (!access_active) begin
          state_d = rtc_time_pkg::ST_RUN;
          step    = tick_1hz;
        end else if (tick_1hz) begin
          state_d = rtc_time_pkg::ST_PEND;
        end
      end
      rtc_time_pkg::ST_PEND: begin
        if (!access_active) begin
          state_d = rtc_time_pkg::ST_RUN;
          step    = 1'b1;
        end
      end
      default: state_d = rtc_time_pkg::ST_RUN;
    endcase
  end

  // --------------------------------------------------------------------
  // Counters, flags and host writes
  // --------------------------------------------------------------------
  // A host write beats a same-cycle advance of the written field
  always_comb begin
    flag_d  = flag_q;
    sec_d   = sec_q;
    min_d   = min_q;
    hour_d  = hour_q;
    day_d   = day_q;
    wday_d  = wday_q;
    month_d = month_q;
    year_d  = year_q;
    cent_d  = cent_q;
    if (step) begin
      sec_d   = sec_n;
      min_d   = min_n;
      hour_d  = hour_n;
      day_d   = day_n;
      wday_d  = wday_n;
      month_d = month_n;
      year_d  = year_n;
      cent_d  = cent_n;
    end
    if (reg_wr) begin
      if (reg_addr == `RTC_OFS_SEC) begin
        flag_d = reg_wdata[`RTC_FLAG_BIT];
        sec_d  = reg_wdata & `RTC_MASK_SEC;
      end else if (reg_addr == `RTC_OFS_MIN) begin
        min_d = reg_wdata & `RTC_MASK_MIN;
      end else if (reg_addr == `RTC_OFS_HOUR) begin
        hour_d = reg_wdata & `RTC_MASK_HOUR;
      end else if (reg_addr == `RTC_OFS_DAY) begin
        day_d = reg_wdata & `RTC_MASK_DAY;
      end else if (reg_addr == `RTC_OFS_WDAY) begin
        wday_d = reg_wdata[2:0];
      end else if (reg_addr == `RTC_OFS_MONTH) begin
        month_d = reg_wdata & `RTC_MASK_MONTH;
        cent_d  = reg_wdata[`RTC_CENT_BIT];
      end else if (reg_addr == `RTC_OFS_YEAR) begin
        year_d = reg_wdata & `RTC_MASK_YEAR;
      end
    end
    // Setting wins over a clearing write in the same cycle
    if (supply_low || osc_stopped)
      flag_d = 1'b1;
  end

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  // Unmapped offsets read zero; data lags the address by one cycle
  always_comb begin
    if (reg_addr == `RTC_OFS_SEC)
      rdata_d = {flag_q, sec_q[6:0]};
    else if (reg_addr == `RTC_OFS_MIN)
      rdata_d = min_q;
    else if (reg_addr == `RTC_OFS_HOUR)
      rdata_d = hour_q;
    else if (reg_addr == `RTC_OFS_DAY)
      rdata_d = day_q;
    else if (reg_addr == `RTC_OFS_WDAY)
      rdata_d = {5'h00, wday_q};
    else if (reg_addr == `RTC_OFS_MONTH)
      rdata_d = {cent_q, 2'h0, month_q[4:0]};
    else if (reg_addr == `RTC_OFS_YEAR)
      rdata_d = year_q;
    else
      rdata_d = `RTC_RST_ZERO;
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q              <= rtc_time_pkg::ST_RUN;
      flag_q               <= `RTC_RST_FLAG;
      clock_integrity_lost <= `RTC_RST_FLAG;
      sec_q                <= `RTC_RST_ZERO;
      min_q                <= `RTC_RST_ZERO;
      hour_q               <= `RTC_RST_ZERO;
      day_q                <= `RTC_FIRST_DAY;
      wday_q               <= rtc_time_pkg::SUNDAY;
      month_q              <= `RTC_FIRST_MONTH;
      year_q               <= `RTC_RST_ZERO;
      cent_q               <= `RTC_RST_CENT;
      reg_rdata            <= `RTC_RST_ZERO;
    end else begin
      state_q              <= state_d;
      flag_q               <= flag_d;
      clock_integrity_lost <= flag_d;
      sec_q                <= sec_d;
      min_q                <= min_d;
      hour_q               <= hour_d;
      day_q                <= day_d;
      wday_q               <= wday_d;
      month_q              <= month_d;
      year_q               <= year_d;
      cent_q               <= cent_d;
      reg_rdata            <= rdata_d;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  sequence s_tick_held;
    access_active && tick_1hz && !reg_wr;
  endsequence

  sequence s_release;
    !access_active && !reg_wr;
  endsequence

  property p_supply_sets;
    @(posedge mclk) disable iff (!reset_n)
      supply_low |=> flag_q && clock_integrity_lost;
  endproperty
  a_supply_sets: assert property (p_supply_sets)
    else $error("supply low did not set integrity flag");

  property p_osc_sets;
    @(posedge mclk) disable iff (!reset_n)
      osc_stopped |=> flag_q;
  endproperty
  a_osc_sets: assert property (p_osc_sets)
    else $error("oscillator stop did not set integrity flag");

  property p_flag_sticky;
    @(posedge mclk) disable iff (!reset_n)
      flag_q && !(reg_wr && reg_addr == `RTC_OFS_SEC) |=> flag_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("integrity flag cleared without a host write");

  property p_sec_range;
    @(posedge mclk) disable iff (!reset_n)
      sec_q[7] == 1'b0 && sec_q[6:4] <= 3'h5 && sec_q[3:0] <= 4'h9;
  endproperty
  a_sec_range: assert property (p_sec_range)
    else $error("seconds out of BCD range");

  property p_field_zero;
    @(posedge mclk) disable iff (!reset_n)
      min_q[7] == 1'b0 && hour_q[7:6] == 2'h0 && day_q[7:6] == 2'h0
      && month_q[7:5] == 3'h0;
  endproperty
  a_field_zero: assert property (p_field_zero)
    else $error("unused counter bits not zero");

  property p_freeze;
    @(posedge mclk) disable iff (!reset_n)
      access_active && !reg_wr |=> $stable(sec_q) && $stable(min_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("time advanced during host access");

  property p_pending;
    @(posedge mclk) disable iff (!reset_n)
      s_tick_held ##1 (access_active && !reg_wr)[*1] ##1 s_release
      |=> sec_q != $past(sec_q);
  endproperty
  a_pending: assert property (p_pending)
    else $error("held tick not applied after access");

  property p_sec_wrap;
    @(posedge mclk) disable iff (!reset_n)
      step && !reg_wr && sec_q == `RTC_SEC_LAST
      |=> sec_q == `RTC_RST_ZERO && min_q != $past(min_q);
  endproperty
  a_sec_wrap: assert property (p_sec_wrap)
    else $error("seconds did not wrap with carry");

  property p_leap_day;
    @(posedge mclk) disable iff (!reset_n)
      step && !reg_wr && month_q == `RTC_FEBRUARY && day_q == 8'h28
      && hour_q == 8'h23 && min_q == 8'h59 && sec_q == 8'h59
      && year_q == 8'h00 |=> day_q == `RTC_DAYS_LEAP;
  endproperty
  a_leap_day: assert property (p_leap_day)
    else $error("leap year February lacks day 29");

  property p_century;
    @(posedge mclk) disable iff (!reset_n)
      step && !reg_wr && year_q == 8'h99 && month_q == 8'h12
      && day_q == 8'h31 && hour_q == 8'h23 && min_q == 8'h59
      && sec_q == 8'h59
      |=> cent_q != $past(cent_q) && year_q == 8'h00;
  endproperty
  a_century: assert property (p_century)
    else $error("century flag not toggled on year rollover");

  // Host may store seven; only the counting itself must stay in range
  property p_wday_range;
    @(posedge mclk) disable iff (!reset_n)
      step && !reg_wr && wday_q <= `RTC_WDAY_LAST
      |=> wday_q <= `RTC_WDAY_LAST;
  endproperty
  a_wday_range: assert property (p_wday_range)
    else $error("weekday counted past six");

endmodule // rtc_time_counters

// file: design/rtc_time_map.svh
// Offsets, field positions, reset values and wrap limits of the time counters
`ifndef RTC_TIME_MAP_SVH
`define RTC_TIME_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RTC_OFS_SEC      8'h02
`define RTC_OFS_MIN      8'h03
`define RTC_OFS_HOUR     8'h04
`define RTC_OFS_DAY      8'h05
`define RTC_OFS_WDAY     8'h06
`define RTC_OFS_MONTH    8'h07
`define RTC_OFS_YEAR     8'h08

// ----------------------------------------------------------------------
// Field positions and write masks
// ----------------------------------------------------------------------
`define RTC_FLAG_BIT     7
`define RTC_CENT_BIT     7
`define RTC_MASK_SEC     8'h7F
`define RTC_MASK_MIN     8'h7F
`define RTC_MASK_HOUR    8'h3F
`define RTC_MASK_DAY     8'h3F
`define RTC_MASK_MONTH   8'h1F
`define RTC_MASK_YEAR    8'hFF

// ----------------------------------------------------------------------
// Wrap limits and first values (BCD)
// ----------------------------------------------------------------------
`define RTC_SEC_LAST     8'h59
`define RTC_MIN_LAST     8'h59
`define RTC_HOUR_LAST    8'h23
`define RTC_WDAY_LAST    3'h6
`define RTC_MONTH_LAST   8'h12
`define RTC_YEAR_LAST    8'h99
`define RTC_FIRST_DAY    8'h01
`define RTC_FIRST_MONTH  8'h01
`define RTC_FEBRUARY     8'h02
`define RTC_DAYS_LEAP    8'h29
`define RTC_DAYS_FEB     8'h28
`define RTC_DAYS_SHORT   8'h30
`define RTC_DAYS_LONG    8'h31

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RTC_RST_FLAG     1'h1
`define RTC_RST_ZERO     8'h00
`define RTC_RST_CENT     1'h0

`endif

// file: design/rtc_time_pkg.sv
// Types and BCD helpers shared by the time counter files
package rtc_time_pkg;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    SUNDAY    = 3'h0,
    MONDAY    = 3'h1,
    TUESDAY   = 3'h2,
    WEDNESDAY = 3'h3,
    THURSDAY  = 3'h4,
    FRIDAY    = 3'h5,
    SATURDAY  = 3'h6
  } weekday_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'h0,
    ST_HOLD = 2'h1,
    ST_PEND = 2'h3
  } hold_state_t;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction

endpackage

// file: design/calendar_step.sv
// One-second advance of the BCD time and calendar fields
`include "rtc_time_map.svh"

module calendar_step (
  // Present time
  input  wire logic [7:0] sec,
  input  wire logic [7:0] min,
  input  wire logic [7:0] hour,
  input  wire logic [7:0] day,
  input  wire logic [2:0] wday,
  input  wire logic [7:0] month,
  input  wire logic [7:0] year,
  input  wire logic       cent,
  // Time one second later
  output logic      [7:0] sec_n,
  output logic      [7:0] min_n,
  output logic      [7:0] hour_n,
  output logic      [7:0] day_n,
  output logic      [2:0] wday_n,
  output logic      [7:0] month_n,
  output logic      [7:0] year_n,
  output logic            cent_n
);

  // --------------------------------------------------------------------
  // Calendar helpers
  // --------------------------------------------------------------------
  // BCD year divisible by 4: even tens need 0/4/8, odd tens need 2/6
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4])
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] m,
                                          input logic [7:0] y);
    if (m == `RTC_FEBRUARY)
      last_day = is_leap(y) ? `RTC_DAYS_LEAP : `RTC_DAYS_FEB;
    else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
      last_day = `RTC_DAYS_SHORT;
    else
      last_day = `RTC_DAYS_LONG;
  endfunction

  // --------------------------------------------------------------------
  // Carry chain
  // --------------------------------------------------------------------
  logic c_sec;
  logic c_min;
  logic c_hour;
  logic c_day;
  logic c_month;
  logic c_year;

  always_comb begin
    c_sec   = (sec == `RTC_SEC_LAST);
    c_min   = c_sec && (min == `RTC_MIN_LAST);
    c_hour  = c_min && (hour == `RTC_HOUR_LAST);
    c_day   = c_hour && (day == last_day(month, year));
    c_month = c_day && (month == `RTC_MONTH_LAST);
    c_year  = c_month && (year == `RTC_YEAR_LAST);

    sec_n = c_sec ? `RTC_RST_ZERO : rtc_time_pkg::bcd_inc(sec);
    min_n = min;
    if (c_sec)
      min_n = c_min ? `RTC_RST_ZERO : rtc_time_pkg::bcd_inc(min);
    hour_n = hour;
    if (c_min)
      hour_n = c_hour ? `RTC_RST_ZERO : rtc_time_pkg::bcd_inc(hour);
    day_n  = day;
    wday_n = wday;
    if (c_hour) begin
      day_n  = c_day ? `RTC_FIRST_DAY : rtc_time_pkg::bcd_inc(day);
      wday_n = (wday == `RTC_WDAY_LAST) ? 3'h0 : wday + 3'h1;
    end
    month_n = month;
    if (c_day)
      month_n = c_month ? `RTC_FIRST_MONTH
                        : rtc_time_pkg::bcd_inc(month);
    year_n = year;
    if (c_month)
      year_n = c_year ? `RTC_RST_ZERO : rtc_time_pkg::bcd_inc(year);
    cent_n = cent ^ c_year;
  end

endmodule // calendar_step

// file: verification/reg_host_model.sv
// Host-side model driving the register port of the time counters
module reg_host_model (
  // Clock
  input  wire logic       mclk,
  // Register port
  output logic            access_active,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    access_active = 1'b0;
    reg_addr      = 8'h00;
    reg_wr        = 1'b0;
    reg_wdata     = 8'h00;
  end

  // ----------------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------------
  task automatic set_access(input logic on);
    @(posedge mclk);
    #1 access_active = on;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr    = 1'b0;
    // Released data shows the inverse, never a stale copy
    reg_wdata = ~d;
  endtask

  // Two edges: lets a pending advance land before the sample
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1 reg_addr = a;
    @(posedge mclk);
    @(posedge mclk);
    #1 d = reg_rdata;
  endtask
endmodule // reg_host_model

// file: verification/tb.sv
// Self-checking bench for the time and date counter registers
`include "rtc_time_map.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic       mclk;
  logic       reset_n;
  logic       tick_1hz;
  logic       supply_low;
  logic       osc_stopped;
  logic       access_active;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       clock_integrity_lost;
  int         fail_count;
  int         tests_run;
  logic [7:0] exp_v [7];
  logic [7:0] d_in  [7];
  logic [7:0] mo_in [7];
  logic [7:0] yr_in [7];
  logic [7:0] d_ex  [7];
  logic [7:0] mo_ex [7];

  rtc_time_counters rtc_time_counters_inst (
    .mclk                 (mclk),
    .reset_n              (reset_n),
    .tick_1hz             (tick_1hz),
    .supply_low           (supply_low),
    .osc_stopped          (osc_stopped),
    .access_active        (access_active),
    .reg_addr             (reg_addr),
    .reg_wr               (reg_wr),
    .reg_wdata            (reg_wdata),
    .reg_rdata            (reg_rdata),
    .clock_integrity_lost (clock_integrity_lost)
  );

  reg_host_model host_inst (
    .mclk          (mclk),
    .access_active (access_active),
    .reg_addr      (reg_addr),
    .reg_wr        (reg_wr),
    .reg_wdata     (reg_wdata),
    .reg_rdata     (reg_rdata)
  );

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host_inst.rd_reg(a, v);
    check(v, exp);
  endtask

  task automatic flag_chk(input logic exp);
    check({7'h00, clock_integrity_lost}, {7'h00, exp});
  endtask

  task automatic tick_pulse;
    @(posedge mclk);
    #1 tick_1hz = 1'b1;
    @(posedge mclk);
    #1 tick_1hz = 1'b0;
  endtask

  // Whole time set in one access, as a careful host would
  task automatic set_time(input logic [7:0] s, input logic [7:0] d,
                          input logic [7:0] w, input logic [7:0] mo,
                          input logic [7:0] y);
    host_inst.set_access(1'b1);
    host_inst.wr_reg(`RTC_OFS_SEC, s);
    host_inst.wr_reg(`RTC_OFS_MIN, 8'h59);
    host_inst.wr_reg(`RTC_OFS_HOUR, 8'h23);
    host_inst.wr_reg(`RTC_OFS_DAY, d);
    host_inst.wr_reg(`RTC_OFS_WDAY, w);
    host_inst.wr_reg(`RTC_OFS_MONTH, mo);
    host_inst.wr_reg(`RTC_OFS_YEAR, y);
    host_inst.set_access(1'b0);
  endtask

  task automatic print_verdict;
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------------
  initial begin
    #(20000 * 50);
    fail_count++;
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    fail_count  = 0;
    tests_run   = 0;
    reset_n     = 1'b0;
    tick_1hz    = 1'b0;
    supply_low  = 1'b0;
    osc_stopped = 1'b0;
    repeat (5) @(posedge mclk);
    #1 reset_n = 1'b1;
    // Start-up values
    exp_v = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
    for (int i = 0; i < 7; i++) begin
      rd_chk(8'h02 + 8'(i), exp_v[i]);
    end
    flag_chk(1'b1);
    // Flag cleared only by a write
    host_inst.wr_reg(`RTC_OFS_SEC, 8'h30);
    rd_chk(`RTC_OFS_SEC, 8'h30);
    flag_chk(1'b0);
    // Unused bits read back zero, unmapped place ignored
    exp_v = '{8'h7F, 8'h3F, 8'h3F, 8'h07, 8'h9F, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      host_inst.wr_reg(8'h03 + 8'(i), 8'hFF);
      rd_chk(8'h03 + 8'(i), exp_v[i]);
    end
    host_inst.wr_reg(8'h09, 8'hFF);
    rd_chk(8'h09, 8'h00);
    rd_chk(`RTC_OFS_YEAR, 8'h00);
    // Full rollover on the last second of year 99
    set_time(8'h59, 8'h31, 8'h06, 8'h12, 8'h99);
    tick_pulse();
    exp_v = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h81, 8'h00};
    for (int i = 0; i < 7; i++) begin
      rd_chk(8'h02 + 8'(i), exp_v[i]);
    end
    // Month ends, leap years included
    d_in  = '{8'h28, 8'h28, 8'h28, 8'h29, 8'h30, 8'h31, 8'h30};
    mo_in = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h04, 8'h01, 8'h01};
    yr_in = '{8'h04, 8'h03, 8'h00, 8'h04, 8'h01, 8'h01, 8'h01};
    d_ex  = '{8'h29, 8'h01, 8'h29, 8'h01, 8'h01, 8'h01, 8'h31};
    mo_ex = '{8'h02, 8'h03, 8'h02, 8'h03, 8'h05, 8'h02, 8'h01};
    for (int i = 0; i < 7; i++) begin
      set_time(8'h59, d_in[i], 8'h03, mo_in[i], yr_in[i]);
      tick_pulse();
      rd_chk(`RTC_OFS_DAY, d_ex[i]);
      rd_chk(`RTC_OFS_MONTH, mo_ex[i]);
      rd_chk(`RTC_OFS_WDAY, 8'h04);
    end
    // Freeze during access, one tick kept, the second lost
    host_inst.wr_reg(`RTC_OFS_SEC, 8'h10);
    host_inst.set_access(1'b1);
    tick_pulse();
    tick_pulse();
    rd_chk(`RTC_OFS_SEC, 8'h10);
    host_inst.set_access(1'b0);
    rd_chk(`RTC_OFS_SEC, 8'h11);
    rd_chk(`RTC_OFS_SEC, 8'h11);
    // Short access: held tick lands right after release
    host_inst.set_access(1'b1);
    tick_pulse();
    host_inst.set_access(1'b0);
    rd_chk(`RTC_OFS_SEC, 8'h12);
    // Low supply sets the flag and beats a clearing write
    @(posedge mclk);
    #1 supply_low = 1'b1;
    host_inst.wr_reg(`RTC_OFS_SEC, 8'h00);
    rd_chk(`RTC_OFS_SEC, 8'h80);
    flag_chk(1'b1);
    @(posedge mclk);
    #1 supply_low = 1'b0;
    tick_pulse();
    rd_chk(`RTC_OFS_SEC, 8'h81);
    host_inst.wr_reg(`RTC_OFS_SEC, 8'h00);
    rd_chk(`RTC_OFS_SEC, 8'h00);
    // Oscillator stop for a single cycle
    @(posedge mclk);
    #1 osc_stopped = 1'b1;
    @(posedge mclk);
    #1 osc_stopped = 1'b0;
    rd_chk(`RTC_OFS_SEC, 8'h80);
    flag_chk(1'b1);
    print_verdict();
  end
endmodule // tb
